/* File: towg_top.sv */
// Output waveform generator for one comparator pair of a 16-bit timer unit.
// Assumes compare hits and counter max/zero are one-cycle pulses on clk that
// line up with cnt_tick, the counter clock enable from the timer's divider.
//
// Summary of operation
// - Software mode drives output from level bit
// - Level and mode ignored in capture mode
// - Mode 0x0 follows level bit on each tick in compare mode
// - Mode 0x7: hit clears, max/zero sets
// - Mode 0x6: hit toggles, max/zero sets
// - Mode 0x5: any pair hit clears output
// - Mode 0x4: any pair hit toggles output
// - Mode 0x3: hit sets, max/zero clears
// - Mode 0x2: hit toggles, max/zero clears
// - Mode 0x1: any pair hit sets output
// - Paired: peer hit replaces max/zero event
// - Per-channel polarity select bit
// - Polarity 1 means active low
// - Pairing bit picks pair hits or max/zero
// - Mode bit 0 compare, 1 capture
`timescale 1ns/1ps

module towg_top
  import towg_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  // AHB-Lite slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Timer events
  input wire logic cnt_tick,
  input wire logic [1:0] cnt_mode,
  input wire logic counter_max,
  input wire logic counter_zero,
  input wire logic match_even,
  input wire logic match_odd,
  // Output pins
  output logic channel_wave_output_even,
  output logic channel_wave_output_odd
);

  // ----------------------------------------------------------------
  // Next active level of one channel
  // ----------------------------------------------------------------
  // Level events beat a toggle; a clear beats a set. Both channels share it.
  function automatic logic wave_next(
    input logic act,
    input logic [15:0] ctl,
    input logic own_hit,
    input logic peer_hit,
    input logic [1:0] cmode,
    input logic cmax,
    input logic czero
  );
    logic edge_evt;
    logic any_hit;
    logic [2:0] mode;
    logic res;
    edge_evt = 1'b0;
    any_hit = 1'b0;
    mode = ctl[TOWG_BIT_MODE_HI:TOWG_BIT_MODE_LO];
    res = act;
    // Second event: peer hit when paired, else max or zero by direction
    if (ctl[TOWG_BIT_PAIRED]) begin
      edge_evt = peer_hit;
    end else if (cmode == TOWG_CNT_DOWN) begin
      edge_evt = czero;
    end else begin
      edge_evt = cmax;
    end
    // Single-event modes react to either hit of the pair when paired
    any_hit = own_hit || (ctl[TOWG_BIT_PAIRED] && peer_hit);
    case (mode)
      TOWG_MODE_SW: begin
        res = ctl[TOWG_BIT_SWLVL];
      end
      TOWG_MODE_SET: begin
        if (any_hit) begin
          res = 1'b1;
        end
      end
      TOWG_MODE_TGL_RST: begin
        if (edge_evt) begin
          res = 1'b0;
        end else if (own_hit) begin
          res = !act;
        end
      end
      TOWG_MODE_SET_RST: begin
        if (edge_evt) begin
          res = 1'b0;
        end else if (own_hit) begin
          res = 1'b1;
        end
      end
      TOWG_MODE_TGL: begin
        if (any_hit) begin
          res = !act;
        end
      end
      TOWG_MODE_RST: begin
        if (any_hit) begin
          res = 1'b0;
        end
      end
      TOWG_MODE_TGL_SET: begin
        if (edge_evt) begin
          res = 1'b1;
        end else if (own_hit) begin
          res = !act;
        end
      end
      TOWG_MODE_RST_SET: begin
        if (own_hit) begin
          res = 1'b0;
        end else if (edge_evt) begin
          res = 1'b1;
        end
      end
      default: begin
        res = act;
      end
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Read mux of the register file
  // ----------------------------------------------------------------
  function automatic logic [31:0] reg_read(
    input logic [7:0] addr,
    input logic [15:0] ce,
    input logic [15:0] co,
    input logic [3:0] st
  );
    logic [31:0] val;
    val = 32'h0000_0000;
    case (addr)
      TOWG_OFS_CTL_EVEN: val = {16'h0000, ce};
      TOWG_OFS_CTL_ODD: val = {16'h0000, co};
      TOWG_OFS_STATUS: val = {28'h000_0000, st};
      default: val = 32'h0000_0000; // Unmapped reads as zero
    endcase
    return val;
  endfunction

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  logic rd_req; // Read accepted in this address phase
  logic [7:0] rd_addr; // Its address
  logic wr_req; // Write data phase in this cycle
  logic [7:0] wr_addr; // Its address

  towg_bus_front u_front (
    .clk(clk),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_req(rd_req),
    .rd_addr(rd_addr),
    .wr_req(wr_req),
    .wr_addr(wr_addr)
  );

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [15:0] ctl_even; // channel_control_reg of the even channel
  logic [15:0] ctl_odd; // channel_control_reg of the odd channel
  logic [15:0] next_ctl_even;
  logic [15:0] next_ctl_odd;
  logic [15:0] wdata_m; // Masked write data, reserved bit forced low

  // Only word writes are expected; any size writes the low half-word
  assign wdata_m = hwdata[15:0] & TOWG_CTL_WMASK;

  // Next values of the control registers
  always_comb begin
    next_ctl_even = ctl_even;
    next_ctl_odd = ctl_odd;
    if (wr_req && (wr_addr == TOWG_OFS_CTL_EVEN)) begin
      next_ctl_even = wdata_m;
    end
    if (wr_req && (wr_addr == TOWG_OFS_CTL_ODD)) begin
      next_ctl_odd = wdata_m;
    end
  end

  // Register the control values
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_even <= TOWG_CTL_RESET;
      ctl_odd <= TOWG_CTL_RESET;
    end else begin
      ctl_even <= next_ctl_even;
      ctl_odd <= next_ctl_odd;
    end
  end

  // ----------------------------------------------------------------
  // Waveform state
  // ----------------------------------------------------------------
  logic act_even; // Active level of the even channel
  logic act_odd; // Active level of the odd channel
  logic next_act_even;
  logic next_act_odd;
  logic next_out_even;
  logic next_out_odd;
  logic cmp_even; // Even channel in comparator mode
  logic cmp_odd; // Odd channel in comparator mode

  assign cmp_even = !ctl_even[TOWG_BIT_CAPSEL];
  assign cmp_odd = !ctl_odd[TOWG_BIT_CAPSEL];

  // Next level of each channel; pin follows on the same edge.
  // Capture mode freezes both the level and the pin, so a capture setup
  // does not glitch the load driven from this pin.
  always_comb begin
    next_act_even = act_even;
    next_act_odd = act_odd;
    next_out_even = channel_wave_output_even;
    next_out_odd = channel_wave_output_odd;
    if (cnt_tick && cmp_even) begin
      next_act_even = wave_next(act_even, ctl_even, match_even, match_odd,
                                cnt_mode, counter_max, counter_zero);
      // Active high unless the flip bit asks for active low
      next_out_even = next_act_even ^ ctl_even[TOWG_BIT_POL];
    end
    if (cnt_tick && cmp_odd) begin
      // Odd channel swaps own and peer hit
      next_act_odd = wave_next(act_odd, ctl_odd, match_odd, match_even,
                               cnt_mode, counter_max, counter_zero);
      next_out_odd = next_act_odd ^ ctl_odd[TOWG_BIT_POL];
    end
  end

  // Register level and pin; reset lands on the inactive level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_even <= 1'b0;
      act_odd <= 1'b0;
      channel_wave_output_even <= 1'b0;
      channel_wave_output_odd <= 1'b0;
    end else begin
      act_even <= next_act_even;
      act_odd <= next_act_odd;
      channel_wave_output_even <= next_out_even;
      channel_wave_output_odd <= next_out_odd;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [3:0] status; // Live output state for software
  logic [31:0] next_hrdata;

  assign status = {act_odd, act_even, channel_wave_output_odd,
                   channel_wave_output_even};

  // Read data is formed in the address phase from next values, so a read
  // right behind a write to the same register sees the new value
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (rd_req) begin
      next_hrdata = reg_read(rd_addr, next_ctl_even, next_ctl_odd, status);
    end
  end

  // Hold data into the data phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // hsize is accepted but not decoded: only whole-word transfers occur
  logic hsize_unused;
  assign hsize_unused = ^hsize;

endmodule

/* File: towg_pkg.sv */
// Constants for the timer output waveform generator of one comparator pair.
// Assumes a single 125 MHz clock; the counter rate arrives as an enable pulse.
package towg_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the AHB-Lite port)
  // ----------------------------------------------------------------
  localparam logic [7:0] TOWG_OFS_CTL_EVEN = 8'h00; // Control of channel m (even)
  localparam logic [7:0] TOWG_OFS_CTL_ODD = 8'h04;  // Control of channel m+1 (odd)
  localparam logic [7:0] TOWG_OFS_STATUS = 8'h08;   // Read-only output state

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int TOWG_BIT_CAPSEL = 0;    // compare_or_capture_select
  localparam int TOWG_BIT_POL = 1;       // output_polarity_flip
  localparam int TOWG_BIT_MODE_LO = 2;   // output_wave_mode low bit
  localparam int TOWG_BIT_MODE_HI = 4;   // output_wave_mode high bit
  localparam int TOWG_BIT_SWLVL = 5;     // sw_output_level
  localparam int TOWG_BIT_PAIRED = 6;    // paired_hit_select

  // Reset value and writable bits (bit 7 is reserved, reads zero)
  localparam logic [15:0] TOWG_CTL_RESET = 16'h0000;
  localparam logic [15:0] TOWG_CTL_WMASK = 16'hFF7F;

  // ----------------------------------------------------------------
  // Status register field positions
  // ----------------------------------------------------------------
  localparam int TOWG_BIT_ST_OUT_EVEN = 0;
  localparam int TOWG_BIT_ST_OUT_ODD = 1;
  localparam int TOWG_BIT_ST_ACT_EVEN = 2;
  localparam int TOWG_BIT_ST_ACT_ODD = 3;

  // ----------------------------------------------------------------
  // Output generation modes
  // ----------------------------------------------------------------
  localparam logic [2:0] TOWG_MODE_SW = 3'h0;
  localparam logic [2:0] TOWG_MODE_SET = 3'h1;
  localparam logic [2:0] TOWG_MODE_TGL_RST = 3'h2;
  localparam logic [2:0] TOWG_MODE_SET_RST = 3'h3;
  localparam logic [2:0] TOWG_MODE_TGL = 3'h4;
  localparam logic [2:0] TOWG_MODE_RST = 3'h5;
  localparam logic [2:0] TOWG_MODE_TGL_SET = 3'h6;
  localparam logic [2:0] TOWG_MODE_RST_SET = 3'h7;

  // ----------------------------------------------------------------
  // Counter direction encoding on cnt_mode
  // ----------------------------------------------------------------
  localparam logic [1:0] TOWG_CNT_UP = 2'h0;
  localparam logic [1:0] TOWG_CNT_DOWN = 2'h1;
  localparam logic [1:0] TOWG_CNT_UPDOWN = 2'h2;

  // ----------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] TOWG_HTRANS_NONSEQ = 2'h2;
  localparam logic TOWG_HRESP_OKAY = 1'b0;

endpackage

/* File: towg_bus_front.sv */
// AHB-Lite slave front end: captures the address phase, answers with no wait.
// Assumes hready is this slave's own hreadyout (single slave on the bus).
`timescale 1ns/1ps

module towg_bus_front
  import towg_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic rd_req,
  output logic [7:0] rd_addr,
  output logic wr_req,
  output logic [7:0] wr_addr
);

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  logic take; // A transfer is accepted at this edge
  logic next_wr_pend; // Write data phase follows
  logic [7:0] next_wr_addr; // Address of that write
  logic wr_pend; // Registered write data phase flag
  logic [7:0] wr_addr_q; // Registered write address

  // Only bit 1 of htrans matters: SEQ never comes, IDLE and BUSY are ignored
  assign take = hsel && hready && htrans[1];
  assign rd_req = take && !hwrite;
  assign rd_addr = haddr[7:0];

  // Zero wait states and always OKAY keep the master simple
  assign hreadyout = 1'b1;
  assign hresp = TOWG_HRESP_OKAY;

  // Next state of the write data phase tracker
  always_comb begin
    next_wr_pend = take && hwrite;
    next_wr_addr = take ? haddr[7:0] : wr_addr_q;
  end

  // Register the address phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr_q <= next_wr_addr;
    end
  end

  assign wr_req = wr_pend;
  assign wr_addr = wr_addr_q;

endmodule

/* File: towg_load.sv */
// Model of the external load hanging on one generated timer output pin.
// Assumes the pin is a push-pull output; the load only observes it.
`timescale 1ns/1ps

module towg_load (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin,
  output logic level,
  output logic [7:0] rises
);
  // ----------------------------------------------------------------
  // Level seen by the load and count of its rising edges
  // ----------------------------------------------------------------
  // Sampled on clk: the load cannot resolve anything finer than that
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level <= 1'b0;
      rises <= 8'h00;
    end else begin
      level <= pin;
      rises <= rises + {7'h00, pin & ~level};
    end
  end
endmodule

/* File: towg_props.sv */
// Assertions on the waveform generator, seen from the top ports only.
// Assumes one clock domain; the control words are shadowed from AHB writes.
`timescale 1ns/1ps

module towg_props
  import towg_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic cnt_tick,
  input wire logic [1:0] cnt_mode,
  input wire logic counter_max,
  input wire logic match_even,
  input wire logic match_odd,
  input wire logic channel_wave_output_even,
  input wire logic channel_wave_output_odd
);
  // ----------------------------------------------------------------
  // Shadow of the control words
  // ----------------------------------------------------------------
  logic wr_pend; // A write is in its data phase
  logic [7:0] wr_addr; // Byte address of that write
  logic [15:0] ce; // Even control copy
  logic [15:0] co; // Odd control copy
  // Copies land at the end of the data phase, as the slave's do
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      ce <= 16'h0000;
      co <= 16'h0000;
    end else begin
      if (wr_pend && wr_addr == TOWG_OFS_CTL_EVEN) ce <= hwdata[15:0];
      if (wr_pend && wr_addr == TOWG_OFS_CTL_ODD) co <= hwdata[15:0];
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end
  wire logic ev_go = cnt_tick && !ce[TOWG_BIT_CAPSEL]; // Even takes an event
  wire logic od_go = cnt_tick && !co[TOWG_BIT_CAPSEL]; // Odd takes an event
  wire logic [2:0] me = ce[4:2]; // Even wave mode
  wire logic [2:0] mo = co[4:2]; // Odd wave mode

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Even channel takes its own hit in a given mode
  sequence s_even_hit(logic [2:0] m);
    ev_go && me == m && match_even;
  endsequence

  chk_tick_hold: assert property (!cnt_tick |=> $stable(channel_wave_output_even)
    && $stable(channel_wave_output_odd)) else $error("pin moved without a tick");
  chk_capture_freeze: assert property (cnt_tick && ce[0] |=> $stable(channel_wave_output_even))
    else $error("pin moved in capture mode");
  chk_sw_level: assert property (ev_go && me == TOWG_MODE_SW |=>
    channel_wave_output_even == (ce[5] ^ ce[1])) else $error("software level wrong");
  chk_hit_clears: assert property (s_even_hit(TOWG_MODE_RST_SET) |=>
    channel_wave_output_even == ce[1]) else $error("reset/set hit not inactive");
  chk_max_clears: assert property (ev_go && me == TOWG_MODE_SET_RST && !ce[6] && counter_max
    && cnt_mode == TOWG_CNT_UP |=> channel_wave_output_even == ce[1]) else $error("max not inactive");
  chk_set_any: assert property (ev_go && me == TOWG_MODE_SET && (match_even || ce[6] && match_odd)
    |=> channel_wave_output_even == !ce[1]) else $error("set hit not active");
  chk_clear_any: assert property (ev_go && me == TOWG_MODE_RST && (match_even || ce[6] && match_odd)
    |=> channel_wave_output_even == ce[1]) else $error("reset hit not inactive");
  chk_toggle_hit: assert property (s_even_hit(TOWG_MODE_TGL) && !match_odd |=>
    channel_wave_output_even != $past(channel_wave_output_even)) else $error("toggle missed");
  chk_peer_sets: assert property (od_go && mo == TOWG_MODE_TGL_SET && co[6] && match_even |=>
    channel_wave_output_odd == !co[1]) else $error("peer hit not active");
endmodule

bind towg_top towg_props u_props (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .cnt_tick(cnt_tick),
  .cnt_mode(cnt_mode), .counter_max(counter_max), .match_even(match_even),
  .match_odd(match_odd), .channel_wave_output_even(channel_wave_output_even),
  .channel_wave_output_odd(channel_wave_output_odd));

/* File: tb_top.sv */
// Self-checking bench for the timer output waveform generator.
// Assumes a lone AHB-Lite slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps

module tb_top;
  import towg_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, cnt_tick = 1'b0, counter_max = 1'b0, counter_zero = 1'b0;
  logic match_even = 1'b0, match_odd = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, cnt_mode = TOWG_CNT_UP;
  logic [2:0] hsize = 3'h2; // Word transfers only
  logic hreadyout, hresp, pin_e, pin_o, load_lvl;
  logic [7:0] load_rises;
  int fail_count = 0, total_checks = 0, cyc = 0;
  logic [31:0] rv; // Last read word

  towg_top u_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cnt_tick(cnt_tick), .cnt_mode(cnt_mode),
    .counter_max(counter_max), .counter_zero(counter_zero), .match_even(match_even),
    .match_odd(match_odd), .channel_wave_output_even(pin_e), .channel_wave_output_odd(pin_o));
  towg_load u_load (.clk(clk), .rstn(rstn), .pin(pin_e), .level(load_lvl), .rises(load_rises));

  // ----------------------------------------------------------------
  // Clock, timeout and closing report
  // ----------------------------------------------------------------
  always #4 clk = ~clk;
  // Whole run is a few hundred cycles; the ceiling only catches a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // AHB-Lite master and event driver
  // ----------------------------------------------------------------
  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= TOWG_HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
    chk({31'h0, hresp}, {31'h0, TOWG_HRESP_OKAY});
  endtask
  // One counter-clock cycle carrying the given events, then a quiet one
  task automatic ev(input logic t, me, mo, mx, zr);
    {cnt_tick, match_even, match_odd, counter_max, counter_zero} <= {t, me, mo, mx, zr};
    @(posedge clk);
    {cnt_tick, match_even, match_odd, counter_max, counter_zero} <= 5'h00;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, unmapped place, writable mask
  task automatic t_regs();
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, a[7:0], 16'h0);
      chk(rv, 32'h0);
    end
    chk({pin_o, pin_e}, 2'h0);
    bus(1'b1, TOWG_OFS_CTL_EVEN, 16'hFFFF);
    bus(1'b0, TOWG_OFS_CTL_EVEN, 16'h0);
    chk(rv, {16'h0, TOWG_CTL_WMASK});
    bus(1'b1, TOWG_OFS_CTL_EVEN, 16'h0040);
  endtask
  // Software level with both polarities, capture freeze, tick gating
  task automatic t_sw();
    cnt_mode <= TOWG_CNT_DOWN;
    for (int p = 0; p < 2; p++) for (int l = 0; l < 2; l++) begin
      bus(1'b1, TOWG_OFS_CTL_EVEN, 16'h0040 | 16'(l << 5) | 16'(p << 1));
      ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      chk({31'h0, pin_e}, 32'(l ^ p));
    end
    bus(1'b1, TOWG_OFS_CTL_EVEN, 16'h0021);
    ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({31'h0, pin_e}, 32'h0);
    bus(1'b1, TOWG_OFS_CTL_EVEN, 16'h0020);
    ev(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({31'h0, pin_e}, 32'h0);
    ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({31'h0, pin_e}, 32'h1);
    bus(1'b0, TOWG_OFS_STATUS, 16'h0);
    chk(rv, 32'h5);
    @(posedge clk);
    chk({31'h0, load_lvl}, 32'h1);
    // Pin rose twice in this scenario: level 1 unflipped, then the final tick
    chk({24'h0, load_rises}, 32'h2);
  endtask
  // Modes 7, 6, 3, 2: even unpaired with max/zero, odd paired with peer hit
  task automatic t_wave();
    logic [2:0] md [4] = '{TOWG_MODE_RST_SET, TOWG_MODE_TGL_SET, TOWG_MODE_SET_RST,
      TOWG_MODE_TGL_RST};
    logic act;
    for (int ch = 0; ch < 2; ch++) for (int cm = 0; cm < 3; cm++) for (int i = 0; i < 4; i++) begin
      cnt_mode <= cm[1:0];
      act = (md[i] >= 3'h6);
      // Park the level opposite to what the max/zero/peer event must give,
      // otherwise a dead event path would still leave the pin right
      bus(1'b1, 8'(ch * 4), {9'h0, ch[0], !act, 3'h0, ch[0], 1'b0});
      ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      chk({31'h0, ch ? pin_o : pin_e}, {31'h0, !act ^ ch[0]});
      bus(1'b1, 8'(ch * 4), {9'h0, ch[0], 1'b0, md[i], ch[0], 1'b0});
      if (ch == 0) ev(1'b1, 1'b0, 1'b0, cm != 1, cm == 1);
      else ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      chk({31'h0, ch ? pin_o : pin_e}, {31'h0, act ^ ch[0]});
      ev(1'b1, ch == 0, ch == 1, 1'b0, 1'b0);
      chk({31'h0, ch ? pin_o : pin_e}, {31'h0, !act ^ ch[0]});
    end
  endtask
  // Same-cycle set and clear; either-hit modes 1, 5, 4
  task automatic t_prio();
    cnt_mode <= TOWG_CNT_UP;
    bus(1'b1, TOWG_OFS_CTL_EVEN, 16'h001C);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    ev(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    chk({31'h0, pin_e}, 32'h0);
    bus(1'b1, TOWG_OFS_CTL_EVEN, 16'h000C);
    ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    ev(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    chk({31'h0, pin_e}, 32'h0);
    bus(1'b1, TOWG_OFS_CTL_EVEN, 16'h0044);
    ev(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    chk({31'h0, pin_e}, 32'h1);
    bus(1'b1, TOWG_OFS_CTL_EVEN, 16'h0054);
    ev(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    chk({31'h0, pin_e}, 32'h0);
    bus(1'b1, TOWG_OFS_CTL_EVEN, 16'h0050);
    ev(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    chk({31'h0, pin_e}, 32'h1);
    ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    chk({31'h0, pin_e}, 32'h0);
    bus(1'b1, TOWG_OFS_CTL_EVEN, 16'h0010);
    ev(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    chk({31'h0, pin_e}, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_sw();
    t_wave();
    t_prio();
    test_done();
  end
endmodule
